// >>> rtl/ifd_decoder.sv
// instruction format decoder and cycle-count sequencer
`timescale 1ns/1ps
`default_nettype none
// Function
// - single words are 24 bits with 8-bit opcode choosing the type
// - only three opcodes span two words; all others use one word
// - two-word instruction holds 48 bits; second word's top 8 bits are zero
// - a lone second word executes as a no-operation with no side effects
// - file-register results go to the file register or working register zero
// - three-operand form: plain first source, modifiable second source and destination
// - bit number comes from a literal or from the first source register
// - literal arithmetic writes a separate destination only when it differs from source
// - most single-word instructions finish in one cycle without taken test or jump
// - taken test or changed program counter adds one no-operation cycle
// - unconditional branches, indirect call, table access and returns take two or three cycles
// - taken skip costs two cycles over one word, three over two words
// - double-word moves complete in two cycles
// - every two-word instruction executes in exactly two cycles
module ifd_decoder
	import ifd_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic word_valid,
	input wire logic [ifd_pkg::IFD_WORD_W-1:0] prog_word,
	input wire logic cond_true,
	input wire logic table_long,
	output logic fetch_ready,
	output logic exec_valid,
	output logic exec_nop,
	output logic [ifd_pkg::IFD_OPC_W-1:0] exec_opcode,
	output logic [ifd_pkg::IFD_WORD_W-1:0] exec_ext_word,
	output logic [ifd_pkg::IFD_REG_W-1:0] base_source_reg,
	output logic [ifd_pkg::IFD_REG_W-1:0] second_source_reg,
	output logic [ifd_pkg::IFD_AMODE_W-1:0] src_amode,
	output logic [ifd_pkg::IFD_REG_W-1:0] result_dest_reg,
	output logic [ifd_pkg::IFD_AMODE_W-1:0] dst_amode,
	output logic dest_write,
	output logic [ifd_pkg::IFD_FILE_W-1:0] file_addr,
	output logic dest_to_working_reg_zero,
	output logic [ifd_pkg::IFD_BITNUM_W-1:0] bit_lit,
	output logic bit_from_reg,
	output logic [ifd_pkg::IFD_LIT_W-1:0] literal,
	output logic [1:0] exec_cycles,
	output logic skip_taken,
	output logic format_error
);
	import ifd_pkg::*;

	logic [IFD_OPC_W-1:0] f_opc;
	logic [IFD_REG_W-1:0] f_base, f_src2, f_dst;
	logic [IFD_AMODE_W-1:0] f_samode, f_damode;
	logic [IFD_BITNUM_W-1:0] f_bit;
	logic f_bitind, f_dsel, f_upper_zero;
	logic [IFD_LIT_W-1:0] f_lit;
	logic [IFD_FILE_W-1:0] f_file;

	ifd_field_split u_split (
		.word(prog_word),
		.opcode(f_opc),
		.base_source_reg(f_base),
		.second_source_reg(f_src2),
		.result_dest_reg(f_dst),
		.src_amode(f_samode),
		.dst_amode(f_damode),
		.bit_lit(f_bit),
		.bit_indirect(f_bitind),
		.dest_is_file(f_dsel),
		.literal(f_lit),
		.file_addr(f_file),
		.upper_zero(f_upper_zero)
	);

	ifd_state_t state, next_state;
	logic [1:0] stall_left, next_stall_left;
	logic skip_pending, next_skip_pending;
	logic skip_second, next_skip_second;
	logic next_fetch_ready, next_exec_valid, next_exec_nop;
	logic [IFD_OPC_W-1:0] next_exec_opcode;
	logic [IFD_WORD_W-1:0] next_exec_ext_word;
	logic [IFD_REG_W-1:0] next_base, next_src2, next_dst;
	logic [IFD_AMODE_W-1:0] next_samode, next_damode;
	logic next_dest_write, next_dest_w0, next_bit_from_reg, next_skip_taken, next_format_error;
	logic [IFD_FILE_W-1:0] next_file_addr;
	logic [IFD_BITNUM_W-1:0] next_bit_lit;
	logic [IFD_LIT_W-1:0] next_literal;
	logic [1:0] next_exec_cycles;
	logic is_two_word, is_cls_default_working_reg, is_cls_file, is_cls_bit, is_cls_lit, is_ctrl_long;
	logic [1:0] cyc;
	logic take_word;

	// a word counts only while fetch_ready is up; words offered during stalls or reset are refused
	assign take_word = word_valid && fetch_ready;

	// class decode of the word being offered
	always_comb begin
		is_two_word = (f_opc == IFD_OPC_CALL2) || (f_opc == IFD_OPC_GOTO2)
			|| (f_opc == IFD_OPC_DO2);
		is_cls_default_working_reg = (f_opc[7:4] == IFD_CLS_DEFAULT_WORKING_REG);
		is_cls_file = (f_opc[7:4] == IFD_CLS_FILE) && (f_opc != IFD_OPC_TABLE)
			&& (f_opc != IFD_OPC_MOVE_DOUBLE);
		is_cls_bit = (f_opc[7:4] == IFD_CLS_BIT);
		is_cls_lit = (f_opc[7:4] == IFD_CLS_LIT);
		is_ctrl_long = (f_opc == IFD_OPC_BRANCH_ALWAYS) || (f_opc == IFD_OPC_IND_CALL)
			|| (f_opc == IFD_OPC_TABLE) || (f_opc == IFD_OPC_RETURN)
			|| (f_opc == IFD_OPC_RETURN_FROM_INTERRUPT);
		// cycle count of the issued instruction
		if (is_two_word || f_opc == IFD_OPC_MOVE_DOUBLE)
			cyc = 2'h2;
		else if (is_ctrl_long)
			cyc = table_long ? IFD_CYC_LONG : 2'h2;
		else if (f_opc == IFD_OPC_BRANCH_COND && cond_true)
			cyc = 2'h2;
		else
			cyc = 2'h1;
	end

	// sequencer: issue, wait out extra cycles, accept second word
	always_comb begin
		next_state = state;
		next_stall_left = stall_left;
		next_skip_pending = skip_pending;
		next_skip_second = skip_second;
		next_fetch_ready = fetch_ready;
		next_exec_valid = 1'b0;
		next_exec_nop = 1'b0;
		next_exec_opcode = exec_opcode;
		next_exec_ext_word = exec_ext_word;
		next_base = base_source_reg;
		next_src2 = second_source_reg;
		next_dst = result_dest_reg;
		next_samode = src_amode;
		next_damode = dst_amode;
		next_dest_write = 1'b0;
		next_file_addr = file_addr;
		next_dest_w0 = dest_to_working_reg_zero;
		next_bit_lit = bit_lit;
		next_bit_from_reg = bit_from_reg;
		next_literal = literal;
		next_exec_cycles = exec_cycles;
		next_skip_taken = 1'b0;
		next_format_error = 1'b0;
		unique case (state)
			IFD_ST_EXEC: begin
				next_fetch_ready = 1'b1;
				if (take_word && skip_pending) begin
					// skipped word retires as a no-operation; a two-word one costs another
					next_skip_pending = 1'b0;
					next_skip_second = is_two_word;
					next_exec_valid = 1'b1;
					next_exec_nop = 1'b1;
					next_exec_opcode = IFD_OPC_NOP;
				end else if (take_word && skip_second) begin
					next_skip_second = 1'b0;
					next_exec_valid = 1'b1;
					next_exec_nop = 1'b1;
					next_exec_opcode = IFD_OPC_NOP;
				end else if (take_word) begin
					next_exec_opcode = f_opc;
					next_exec_nop = (f_opc == IFD_OPC_NOP);
					next_base = f_base;
					next_src2 = f_src2;
					next_samode = is_cls_default_working_reg ? f_samode : '0;
					next_dst = f_dst;
					next_damode = f_damode;
					next_file_addr = f_file;
					next_dest_w0 = is_cls_file && !f_dsel;
					next_bit_lit = f_bit;
					next_bit_from_reg = is_cls_bit && f_bitind;
					next_literal = f_lit;
					next_exec_cycles = cyc;
					if (is_cls_lit)
						next_dest_write = (f_dst != f_base);
					else
						next_dest_write = is_cls_default_working_reg || (is_cls_file && f_dsel);
					if (f_opc == IFD_OPC_SKIP && cond_true) begin
						next_skip_pending = 1'b1;
						next_skip_taken = 1'b1;
					end
					if (is_two_word) begin
						// hold issue until the second word arrives
						next_state = IFD_ST_WORD2;
					end else begin
						next_exec_valid = 1'b1;
						if (cyc > 2'h1) begin
							next_stall_left = cyc - 2'h1;
							next_fetch_ready = 1'b0;
							next_state = IFD_ST_STALL;
						end
					end
				end
			end
			IFD_ST_WORD2: begin
				// stay ready until the second word shows up, so a fetch gap cannot hang the core
				next_fetch_ready = 1'b1;
				if (take_word) begin
					next_fetch_ready = 1'b0;
					next_exec_ext_word = prog_word;
					next_format_error = !f_upper_zero;
					next_exec_valid = 1'b1;
					next_stall_left = 2'h1;
					next_state = IFD_ST_STALL;
				end
			end
			IFD_ST_STALL: begin
				// added cycles retire as no-operations
				next_exec_valid = 1'b1;
				next_exec_nop = 1'b1;
				next_exec_opcode = IFD_OPC_NOP;
				next_stall_left = stall_left - 2'h1;
				if (stall_left == 2'h1) begin
					next_fetch_ready = 1'b1;
					next_state = IFD_ST_EXEC;
				end
			end
			default: begin
				next_state = IFD_ST_EXEC;
			end
		endcase
	end

	// registered state and outputs, synchronous reset
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state <= IFD_ST_EXEC;
			stall_left <= 2'h0;
			skip_pending <= 1'b0;
			skip_second <= 1'b0;
			fetch_ready <= 1'b0;
			exec_valid <= 1'b0;
			exec_nop <= 1'b0;
			exec_opcode <= IFD_OPC_NOP;
			exec_ext_word <= '0;
			base_source_reg <= '0;
			second_source_reg <= '0;
			src_amode <= '0;
			result_dest_reg <= '0;
			dst_amode <= '0;
			dest_write <= 1'b0;
			file_addr <= '0;
			dest_to_working_reg_zero <= 1'b0;
			bit_lit <= '0;
			bit_from_reg <= 1'b0;
			literal <= '0;
			exec_cycles <= 2'h1;
			skip_taken <= 1'b0;
			format_error <= 1'b0;
		end else begin
			state <= next_state;
			stall_left <= next_stall_left;
			skip_pending <= next_skip_pending;
			skip_second <= next_skip_second;
			fetch_ready <= next_fetch_ready;
			exec_valid <= next_exec_valid;
			exec_nop <= next_exec_nop;
			exec_opcode <= next_exec_opcode;
			exec_ext_word <= next_exec_ext_word;
			base_source_reg <= next_base;
			second_source_reg <= next_src2;
			src_amode <= next_samode;
			result_dest_reg <= next_dst;
			dst_amode <= next_damode;
			dest_write <= next_dest_write;
			file_addr <= next_file_addr;
			dest_to_working_reg_zero <= next_dest_w0;
			bit_lit <= next_bit_lit;
			bit_from_reg <= next_bit_from_reg;
			literal <= next_literal;
			exec_cycles <= next_exec_cycles;
			skip_taken <= next_skip_taken;
			format_error <= next_format_error;
		end
	end
endmodule // ifd_decoder
`default_nettype wire

// >>> rtl/ifd_pkg.sv
// package of constants and types for the instruction format and timing decoder
package ifd_pkg;
	localparam int IFD_WORD_W = 24;
	localparam int IFD_OPC_W = 8;
	localparam int IFD_OPC_LSB = 16;
	localparam int IFD_REG_W = 4;
	// operand field positions
	localparam int IFD_DST_LSB = 7;
	localparam int IFD_SRC2_LSB = 0;
	localparam int IFD_BASE_LSB = 11;
	localparam int IFD_AMODE_S_LSB = 4;
	localparam int IFD_AMODE_D_LSB = 15;
	localparam int IFD_AMODE_W = 3;
	localparam int IFD_BITNUM_LSB = 12;
	localparam int IFD_BITNUM_W = 4;
	localparam int IFD_BITIND_BIT = 11;
	localparam int IFD_DSEL_BIT = 13;
	localparam int IFD_LIT_LSB = 4;
	localparam int IFD_LIT_W = 10;
	localparam int IFD_FILE_W = 13;
	localparam logic [3:0] IFD_DEFAULT_WORKING_REG_ZERO = 4'h0;
	// opcode class codes in the upper four bits of opcode, plus the full nop and skip opcodes
	localparam logic [7:0] IFD_OPC_NOP = 8'h00;
	localparam logic [3:0] IFD_CLS_DEFAULT_WORKING_REG = 4'h4;
	localparam logic [3:0] IFD_CLS_FILE = 4'hB;
	localparam logic [3:0] IFD_CLS_BIT = 4'hA;
	localparam logic [3:0] IFD_CLS_LIT = 4'h5;
	localparam logic [7:0] IFD_OPC_SKIP = 8'hE6;
	// the three two-word instructions
	localparam logic [7:0] IFD_OPC_CALL2 = 8'h02;
	localparam logic [7:0] IFD_OPC_GOTO2 = 8'h04;
	localparam logic [7:0] IFD_OPC_DO2 = 8'h08;
	// single-word multi-cycle controls
	localparam logic [7:0] IFD_OPC_BRANCH_ALWAYS = 8'h37;
	localparam logic [7:0] IFD_OPC_BRANCH_COND = 8'h30;
	localparam logic [7:0] IFD_OPC_IND_CALL = 8'h01;
	localparam logic [7:0] IFD_OPC_TABLE = 8'hBA;
	localparam logic [7:0] IFD_OPC_RETURN = 8'h06;
	localparam logic [7:0] IFD_OPC_RETURN_FROM_INTERRUPT = 8'h07;
	localparam logic [7:0] IFD_OPC_MOVE_DOUBLE = 8'hBE;
	localparam logic [1:0] IFD_CYC_LONG = 2'h3;
	typedef enum logic [1:0] {
		IFD_ST_EXEC = 2'b00,
		IFD_ST_STALL = 2'b01,
		IFD_ST_WORD2 = 2'b11
	} ifd_state_t;
endpackage : ifd_pkg

// >>> rtl/ifd_field_split.sv
// combinational splitter of a program word into operand fields
`timescale 1ns/1ps
`default_nettype none
module ifd_field_split
	import ifd_pkg::*;
(
	input wire logic [ifd_pkg::IFD_WORD_W-1:0] word,
	output logic [ifd_pkg::IFD_OPC_W-1:0] opcode,
	output logic [ifd_pkg::IFD_REG_W-1:0] base_source_reg,
	output logic [ifd_pkg::IFD_REG_W-1:0] second_source_reg,
	output logic [ifd_pkg::IFD_REG_W-1:0] result_dest_reg,
	output logic [ifd_pkg::IFD_AMODE_W-1:0] src_amode,
	output logic [ifd_pkg::IFD_AMODE_W-1:0] dst_amode,
	output logic [ifd_pkg::IFD_BITNUM_W-1:0] bit_lit,
	output logic bit_indirect,
	output logic dest_is_file,
	output logic [ifd_pkg::IFD_LIT_W-1:0] literal,
	output logic [ifd_pkg::IFD_FILE_W-1:0] file_addr,
	output logic upper_zero
);
	import ifd_pkg::*;

	// fixed slicing; all classes share positions so one split serves every decode path
	assign opcode = word[IFD_OPC_LSB +: IFD_OPC_W];
	assign base_source_reg = word[IFD_BASE_LSB +: IFD_REG_W];
	assign second_source_reg = word[IFD_SRC2_LSB +: IFD_REG_W];
	assign result_dest_reg = word[IFD_DST_LSB +: IFD_REG_W];
	assign src_amode = word[IFD_AMODE_S_LSB +: IFD_AMODE_W];
	assign dst_amode = word[IFD_AMODE_D_LSB - 1 -: IFD_AMODE_W];
	assign bit_lit = word[IFD_BITNUM_LSB +: IFD_BITNUM_W];
	assign bit_indirect = word[IFD_BITIND_BIT];
	assign dest_is_file = word[IFD_DSEL_BIT];
	assign literal = word[IFD_LIT_LSB +: IFD_LIT_W];
	assign file_addr = word[IFD_FILE_W-1:0];
	assign upper_zero = (word[IFD_OPC_LSB +: IFD_OPC_W] == IFD_OPC_NOP);
endmodule // ifd_field_split
`default_nettype wire

// >>> dv/ifd_decoder_chk.sv
// concurrent checks on the decoder ports
`timescale 1ns/1ps
`default_nettype none
module ifd_decoder_chk
	import ifd_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic word_valid,
	input wire logic [ifd_pkg::IFD_WORD_W-1:0] prog_word,
	input wire logic cond_true,
	input wire logic table_long,
	input wire logic fetch_ready,
	input wire logic exec_valid,
	input wire logic exec_nop,
	input wire logic [ifd_pkg::IFD_OPC_W-1:0] exec_opcode,
	input wire logic [1:0] exec_cycles,
	input wire logic dest_write,
	input wire logic skip_taken,
	input wire logic format_error
);
	wire take = fetch_ready && word_valid;
	wire [7:0] op = prog_word[23:16];
	wire two = op == IFD_OPC_CALL2 || op == IFD_OPC_GOTO2 || op == IFD_OPC_DO2;
	wire lit_diff = prog_word[14:11] != prog_word[10:7];
	wire upper_nz = prog_word[23:16] != 8'h00;
	logic arm;
	logic next_arm;
	// arm marks a fresh instruction; second words and skipped words must not trip the checks
	always_comb begin
		next_arm = arm;
		if (rst)
			next_arm = 1'b1;
		else if (take)
			next_arm = !(two || op == IFD_OPC_SKIP);
	end
	always_ff @(posedge sys_clk) begin
		arm <= next_arm;
	end
	wire go = take && arm;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	chk_nop_code: assert property (exec_valid && exec_nop |-> exec_opcode == IFD_OPC_NOP)
		else $error("opcode not cleared on a nop cycle");
	chk_one_cycle: assert property (go && op[7:4] == IFD_CLS_DEFAULT_WORKING_REG |=> exec_valid && !exec_nop
		&& exec_cycles == 2'h1 && dest_write) else $error("register op not single cycle");
	chk_branch_seq: assert property (go && op == IFD_OPC_BRANCH_ALWAYS && !table_long
		|=> exec_valid && exec_cycles == 2'h2 ##1 exec_valid && exec_nop)
		else $error("branch not followed by one nop");
	chk_long_table: assert property (go && op == IFD_OPC_TABLE && table_long
		|=> exec_cycles == IFD_CYC_LONG ##1 (exec_valid && exec_nop) [*2])
		else $error("long table access not three cycles");
	chk_cond_cost: assert property (go && op == IFD_OPC_BRANCH_COND
		|=> exec_cycles == ($past(cond_true) ? 2'h2 : 2'h1)) else $error("conditional cost wrong");
	chk_dbl_move: assert property (go && op == IFD_OPC_MOVE_DOUBLE && !table_long
		|=> exec_cycles == 2'h2 ##1 exec_nop) else $error("double move not two cycles");
	chk_word1_quiet: assert property (go && two |=> !exec_valid)
		else $error("first word issued alone");
	chk_two_word: assert property (go && two ##1 take |=> exec_valid && !exec_nop
		&& exec_cycles == 2'h2 ##1 exec_valid && exec_nop) else $error("two-word not two cycles");
	chk_upper_zero: assert property (go && two ##1 take |=> format_error == $past(upper_nz))
		else $error("second word upper byte flag wrong");
	chk_lone_nop: assert property (go && op == IFD_OPC_NOP
		|=> exec_valid && exec_nop && !dest_write) else $error("lone second word had effect");
	chk_skip_flag: assert property (go && op == IFD_OPC_SKIP && cond_true
		|=> skip_taken && !exec_nop) else $error("taken skip not flagged");
	chk_lit_dest: assert property (go && op[7:4] == IFD_CLS_LIT
		|=> dest_write == $past(lit_diff)) else $error("literal destination write wrong");
endmodule // ifd_decoder_chk
bind ifd_decoder ifd_decoder_chk u_ifd_decoder_chk (.*);
`default_nettype wire

// >>> dv/ifd_decoder_bench.sv
// self-checking bench for the instruction decoder
`timescale 1ns/1ps
`default_nettype none
module ifd_decoder_bench;
	import ifd_pkg::*;
	typedef struct {logic [23:0] w; logic c, t, k, dw, wz, br; int n;} ifd_row_t;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic word_valid = 1'b0;
	logic cond_true = 1'b0;
	logic table_long = 1'b0;
	logic [23:0] prog_word = 24'h000000;
	logic fetch_ready, exec_valid, exec_nop, dest_write, skip_taken, format_error;
	logic dest_to_working_reg_zero, bit_from_reg;
	logic [7:0] exec_opcode, f_op;
	logic [23:0] exec_ext_word;
	logic [3:0] base_source_reg, bit_lit, second_source_reg, result_dest_reg;
	logic [2:0] src_amode, dst_amode;
	logic [9:0] literal;
	logic [1:0] exec_cycles, f_cyc;
	logic [12:0] file_addr;
	logic [7:0] tw [3];
	int fails = 0;
	int n_checks = 0;
	int nv, nn, ns, nf, nd;
	ifd_row_t rows [17];
	ifd_decoder u_ifd_decoder (.*);
	always #2 sys_clk = ~sys_clk;
	// tally pulses at the rising edge, which still sees the settled values of the cycle
	always @(posedge sys_clk) begin
		nv += (exec_valid === 1'b1);
		nn += (exec_valid === 1'b1 && exec_nop === 1'b1);
		ns += (skip_taken === 1'b1);
		nf += (format_error === 1'b1);
		nd += (dest_write === 1'b1);
		if (exec_valid === 1'b1 && exec_nop !== 1'b1) begin
			f_op = exec_opcode;
			f_cyc = exec_cycles;
		end
	end
	task wrap_up;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task clr;
		nv = 0;
		nn = 0;
		ns = 0;
		nf = 0;
		nd = 0;
		f_op = 8'hFF;
		f_cyc = 2'h0;
	endtask
	// offer one word at the falling edge and hold it over the taking edge
	task put(input logic [23:0] w, input logic c, input logic t);
		int i;
		for (i = 0; i < 20 && fetch_ready !== 1'b1; i++)
			@(negedge sys_clk);
		chk("fetch_ready", 1, fetch_ready);
		if (fetch_ready !== 1'b1)
			wrap_up();
		word_valid = 1'b1;
		prog_word = w;
		cond_true = c;
		table_long = t;
		@(negedge sys_clk);
	endtask
	// long enough for a three-cycle instruction to retire all its nops
	task fin(input string nm);
		word_valid = 1'b0;
		cond_true = 1'b0;
		table_long = 1'b0;
		repeat (7) @(negedge sys_clk);
		$display("test %s done", nm);
	endtask
	initial begin
		rows = '{'{24'h41A5B7, 0, 0, 1, 1, 0, 0, 1}, '{24'hB42123, 0, 0, 1, 1, 0, 0, 1},
			'{24'hB40123, 0, 0, 1, 0, 1, 0, 1}, '{24'h510880, 0, 0, 1, 0, 0, 0, 1},
			'{24'h510900, 0, 0, 1, 1, 0, 0, 1}, '{24'hA30800, 0, 0, 1, 0, 0, 1, 1},
			'{24'hA35000, 0, 0, 1, 0, 0, 0, 1}, '{24'h370000, 0, 0, 0, 0, 0, 0, 2},
			'{24'h010000, 0, 0, 0, 0, 0, 0, 2}, '{24'hBA0000, 0, 0, 0, 0, 0, 0, 2},
			'{24'h060000, 0, 0, 0, 0, 0, 0, 2}, '{24'h070000, 0, 0, 0, 0, 0, 0, 2},
			'{24'hBE0000, 0, 0, 0, 0, 0, 0, 2}, '{24'h300000, 1, 0, 0, 0, 0, 0, 2},
			'{24'h300000, 0, 0, 0, 0, 0, 0, 1}, '{24'h370000, 0, 1, 0, 0, 0, 0, 3},
			'{24'hBA0000, 0, 1, 0, 0, 0, 0, 3}};
		tw = '{IFD_OPC_CALL2, IFD_OPC_GOTO2, IFD_OPC_DO2};
		repeat (12) @(negedge sys_clk);
		chk("fetch_ready", 0, fetch_ready);
		chk("exec_valid", 0, exec_valid);
		chk("exec_cycles", 1, exec_cycles);
		rst = 1'b0;
		foreach (rows[i]) begin
			clr();
			put(rows[i].w, rows[i].c, rows[i].t);
			fin("row");
			chk("exec_count", rows[i].n, nv);
			chk("exec_cycles", rows[i].n, f_cyc);
			chk("opcode", rows[i].w[23:16], f_op);
			if (rows[i].k) begin
				chk("dest_write", rows[i].dw, nd);
				chk("to_reg_zero", rows[i].wz, dest_to_working_reg_zero);
				chk("bit_from_reg", rows[i].br, bit_from_reg);
				chk("base_reg", rows[i].w[14:11], base_source_reg);
				chk("src2_reg", rows[i].w[3:0], second_source_reg);
				chk("dest_reg", rows[i].w[10:7], result_dest_reg);
				chk("dst_amode", rows[i].w[14:12], dst_amode);
				if (rows[i].w[23:20] == IFD_CLS_DEFAULT_WORKING_REG)
					chk("src_amode", rows[i].w[6:4], src_amode);
				else
					chk("src_amode", 0, src_amode);
			end
			if (rows[i].w[23:20] == IFD_CLS_LIT)
				chk("literal", rows[i].w[13:4], literal);
			if (rows[i].w[23:20] == IFD_CLS_FILE)
				chk("file_addr", rows[i].w[12:0], file_addr);
			if (rows[i].w[23:20] == IFD_CLS_BIT)
				chk("bit_lit", rows[i].w[15:12], bit_lit);
		end
		foreach (tw[i]) begin
			clr();
			put({tw[i], 16'h0000}, 0, 0);
			put(24'h00ABCD, 0, 0);
			fin("two_word");
			chk("exec_count", 2, nv);
			chk("nop_count", 1, nn);
			chk("opcode", tw[i], f_op);
			chk("ext_word", 24'h00ABCD, exec_ext_word);
			chk("format_error", 0, nf);
		end
		clr();
		put(24'h041111, 0, 0);
		put(24'h5A1234, 0, 0);
		fin("bad_second_word");
		chk("format_error", 1, nf);
		clr();
		put(24'h001234, 0, 0);
		fin("lone_second_word");
		chk("nop_count", 1, nn);
		chk("dest_write", 0, nd);
		clr();
		put(24'hE60000, 1, 0);
		put(24'h41A5B7, 0, 0);
		fin("skip_one");
		chk("skip_taken", 1, ns);
		chk("exec_count", 2, nv);
		chk("dest_write", 0, nd);
		clr();
		put(24'hE60000, 1, 0);
		put(24'h021111, 0, 0);
		put(24'h002222, 0, 0);
		fin("skip_two");
		chk("exec_count", 3, nv);
		chk("nop_count", 2, nn);
		// second word held back one cycle: decoder must stay ready for it
		clr();
		put({IFD_OPC_GOTO2, 16'h0000}, 0, 0);
		word_valid = 1'b0;
		@(negedge sys_clk);
		chk("fetch_ready", 1, fetch_ready);
		put(24'h00BEEF, 0, 0);
		fin("two_word_gap");
		chk("exec_count", 2, nv);
		chk("ext_word", 24'h00BEEF, exec_ext_word);
		// reset in mid stall with a word waiting: it is refused until fetch_ready rises
		put(24'h370000, 0, 1);
		rst = 1'b1;
		word_valid = 1'b1;
		prog_word = 24'h41A5B7;
		repeat (2) @(negedge sys_clk);
		clr();
		chk("exec_valid", 0, exec_valid);
		chk("fetch_ready", 0, fetch_ready);
		rst = 1'b0;
		@(negedge sys_clk);
		chk("exec_valid", 0, exec_valid);
		chk("fetch_ready", 1, fetch_ready);
		@(negedge sys_clk);
		fin("mid_reset");
		chk("exec_count", 1, nv);
		chk("opcode", 8'h41, f_op);
		// back to back single-cycle words
		clr();
		put(24'h41A5B7, 0, 0);
		put(24'h510900, 0, 0);
		put(24'hA35000, 0, 0);
		fin("back_to_back");
		chk("exec_count", 3, nv);
		chk("dest_write", 2, nd);
		wrap_up();
	end
endmodule // ifd_decoder_bench
`default_nettype wire
